// ===== shared/dcb_pkg.sv
// Behaviour
// - six forwarded differential clock pairs, complement inverted
// - four active-low row selects, one per row
// - 13-bit multiplexed row and column address
// - 2-bit bank address selects bank
// - row, column, write strobes encode commands
// - 64-bit data bus, driven for writes
// - write strobe edges centred in data
// - read data captured on memory strobes
// - nine strobes, one per byte lane
// - clock enables hold init and self-refresh
// - idle rows powered down, woken before use
// - clock enables change on forwarded rising edge
// - check byte travels with every data beat
package dcb_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int N_CLK_PAIRS = 6;
  localparam int N_ROWS = 4;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DATA_W = 64;
  localparam int CHECK_W = 8;
  localparam int N_LANES = 9;
  localparam int BEAT_W = DATA_W + CHECK_W;
  localparam logic [3:0] ROWS_ALL = 4'hF;
  localparam logic [3:0] ROWS_NONE = 4'h0;
  // ----------------------------------------------------------------
  // timing: one forwarded clock period is eight system clocks
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_TIME_NS = 200000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int RD_SLOTS = 4;
  localparam logic [2:0] PH_LAST = 3'h7;
  localparam logic [2:0] PH_CLK_FALL = 3'h4;
  localparam logic [2:0] PH_BEAT1 = 3'h4;
  localparam logic [2:0] PH_STB_RISE = 3'h2;
  localparam logic [2:0] PH_STB_FALL = 3'h6;
  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    cmd_nop, cmd_activate, cmd_read, cmd_write,
    cmd_precharge, cmd_refresh, cmd_mode_set
  } dcb_cmd_type;

  // returns {row_strobe_n, column_strobe_n, write_strobe_n}
  function automatic logic [2:0] dcb_cmd_pins(input dcb_cmd_type c);
    unique case (c)
      cmd_activate: dcb_cmd_pins = 3'h3;
      cmd_read: dcb_cmd_pins = 3'h5;
      cmd_write: dcb_cmd_pins = 3'h4;
      cmd_precharge: dcb_cmd_pins = 3'h2;
      cmd_refresh: dcb_cmd_pins = 3'h1;
      cmd_mode_set: dcb_cmd_pins = 3'h0;
      default: dcb_cmd_pins = 3'h7;
    endcase
  endfunction : dcb_cmd_pins
endpackage : dcb_pkg

// ===== src/dcb_byte_lane.sv
module dcb_byte_lane (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // launch values for the next cycle, and read capture enable
  input wire logic nxt_drive,
  input wire logic [7:0] nxt_byte,
  input wire logic nxt_strobe,
  input wire logic capture_en,
  // lane pins
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out_ff,
  output logic dq_oe_ff,
  input wire logic dqs_in,
  output logic dqs_out_ff,
  output logic dqs_oe_ff,
  // captured read beat
  output logic [7:0] rd_byte_ff,
  output logic rd_edge_ff
);
  logic [7:0] dq_meta_ff;
  logic [7:0] dq_sync_ff;
  logic dqs_meta_ff;
  logic dqs_sync_ff;
  logic dqs_last_ff;
  wire dqs_edge = dqs_sync_ff ^ dqs_last_ff;
  wire take_beat = dqs_edge & capture_en;

  // ----------------------------------------------------------------
  // write launch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_out_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
      dqs_out_ff <= 1'b0;
      dqs_oe_ff <= 1'b0;
    end
    else
    begin
      dq_out_ff <= nxt_drive ? nxt_byte : 8'h00;
      dq_oe_ff <= nxt_drive;
      dqs_out_ff <= nxt_strobe;
      dqs_oe_ff <= nxt_drive;
    end
  end

  // ----------------------------------------------------------------
  // read capture
  // ----------------------------------------------------------------
  // data and strobe share one synchroniser depth, so the data sample
  // seen with a strobe edge was taken at the same instant
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_meta_ff <= 8'h00;
      dq_sync_ff <= 8'h00;
      dqs_meta_ff <= 1'b0;
      dqs_sync_ff <= 1'b0;
      dqs_last_ff <= 1'b0;
    end
    else
    begin
      dq_meta_ff <= dq_in;
      dq_sync_ff <= dq_meta_ff;
      dqs_meta_ff <= dqs_in;
      dqs_sync_ff <= dqs_meta_ff;
      dqs_last_ff <= dqs_sync_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_byte_ff <= 8'h00;
      rd_edge_ff <= 1'b0;
    end
    else
    begin
      rd_edge_ff <= take_beat;
      if (take_beat)
        rd_byte_ff <= dq_sync_ff;
    end
  end
endmodule : dcb_byte_lane

// ===== src/dcb_channel.sv
module dcb_channel #(
  parameter int INIT_CYCLES = dcb_pkg::INIT_CYCLES,
  parameter int RD_SLOTS = dcb_pkg::RD_SLOTS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // command port
  input wire logic cmd_valid,
  input wire dcb_pkg::dcb_cmd_type cmd_code,
  input wire logic [1:0] cmd_row,
  input wire logic [1:0] cmd_bank,
  input wire logic [12:0] cmd_addr,
  input wire logic [63:0] wr_data0,
  input wire logic [7:0] wr_check0,
  input wire logic [63:0] wr_data1,
  input wire logic [7:0] wr_check1,
  output logic cmd_ack,
  // read return
  output logic rd_valid,
  output logic [63:0] rd_data,
  output logic [7:0] rd_check,
  // power control
  input wire logic [3:0] pdn_req,
  input wire logic sref_req,
  output logic init_done,
  output logic sref_active,
  // memory command pins
  output logic [5:0] mem_fwd_clk_true,
  output logic [5:0] mem_fwd_clk_comp,
  output logic [3:0] row_select_n,
  output logic [3:0] row_clock_enable,
  output logic [12:0] mem_row_col_addr,
  output logic [1:0] bank_addr,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  // memory data pins
  input wire logic [63:0] mem_data_bus_in,
  output logic [63:0] mem_data_bus_out,
  output logic [63:0] mem_data_bus_oe,
  input wire logic [7:0] check_byte_bus_in,
  output logic [7:0] check_byte_bus_out,
  output logic [7:0] check_byte_bus_oe,
  input wire logic [8:0] byte_lane_strobe_in,
  output logic [8:0] byte_lane_strobe_out,
  output logic [8:0] byte_lane_strobe_oe
);
  localparam int INIT_W = $clog2(INIT_CYCLES + 1);

  if (INIT_CYCLES < 1 || RD_SLOTS < 1 || RD_SLOTS > 8)
  begin : g_bad_param
    $error("dcb_channel: INIT_CYCLES or RD_SLOTS out of range");
  end

  typedef enum logic [2:0] {
    st_init, st_idle, st_wcmd, st_wdata, st_rwait, st_sref
  } dcb_state_type;

  function automatic logic [3:0] row_onehot(input logic [1:0] r);
    row_onehot = 4'h1 << r;
  endfunction : row_onehot

  dcb_state_type state_ff;
  dcb_state_type nxt_state;
  logic [2:0] phase_ff;
  logic [INIT_W-1:0] init_cnt_ff;
  logic [2:0] rd_cnt_ff;
  logic [5:0] clk_true_ff;
  logic [5:0] clk_comp_ff;
  logic fwd_prev_ff;
  logic [3:0] sel_n_ff;
  logic [3:0] nxt_sel_n;
  logic [3:0] cke_ff;
  logic [3:0] nxt_cke;
  logic [2:0] pins_ff;
  logic [2:0] nxt_pins;
  logic [12:0] addr_ff;
  logic [1:0] bank_ff;
  logic ack_ff;
  logic init_done_ff;
  logic sref_ff;
  logic [71:0] wbuf0_ff;
  logic [71:0] wbuf1_ff;
  logic rd_valid_ff;
  logic [71:0] rd_beat_ff;
  logic [8:0] lane_oe;
  logic [8:0] lane_edge;
  logic [71:0] lane_rd;
  logic [71:0] all_dq_out;
  logic [71:0] all_oe;

  wire [2:0] nxt_phase = phase_ff + 3'h1;
  wire slot = phase_ff == dcb_pkg::PH_LAST;
  wire idle = state_ff == st_idle;
  wire init_end = init_cnt_ff == INIT_W'(INIT_CYCLES - 1);
  wire [3:0] cmd_mask = row_onehot(cmd_row);
  // command waits until its row is awake
  wire take = slot & idle & cmd_valid & ~sref_req & cke_ff[cmd_row];
  wire sref_go = slot & idle & sref_req & (&cke_ff);
  wire rd_done = rd_cnt_ff == 3'h0;
  wire [71:0] wr_beat = (nxt_phase < dcb_pkg::PH_BEAT1) ? wbuf0_ff
                                                         : wbuf1_ff;
  wire nxt_drive = nxt_state == st_wdata;
  // strobe edges at quarter points of each beat pair
  wire nxt_strobe = nxt_drive & (nxt_phase >= dcb_pkg::PH_STB_RISE) &
                    (nxt_phase < dcb_pkg::PH_STB_FALL);
  wire capture_en = state_ff == st_rwait;

  // ----------------------------------------------------------------
  // forwarded clock
  // ----------------------------------------------------------------
  // divided clock, both polarities registered
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // start in the low half so the first pulse is a full one
      phase_ff <= dcb_pkg::PH_CLK_FALL;
      clk_true_ff <= 6'h00;
      clk_comp_ff <= 6'h3F;
      fwd_prev_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      clk_true_ff <= {6{nxt_phase < dcb_pkg::PH_CLK_FALL}};
      clk_comp_ff <= {6{nxt_phase >= dcb_pkg::PH_CLK_FALL}};
      fwd_prev_ff <= clk_true_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      st_init: if (slot && init_end) nxt_state = st_idle;
      st_idle:
        if (take && cmd_code == dcb_pkg::cmd_read)
          nxt_state = st_rwait;
        else if (take && cmd_code == dcb_pkg::cmd_write)
          nxt_state = st_wcmd;
        else if (sref_go)
          nxt_state = st_sref;
      st_wcmd: if (slot) nxt_state = st_wdata;
      st_wdata: if (slot) nxt_state = st_idle;
      st_rwait: if (slot && rd_done) nxt_state = st_idle;
      st_sref: if (slot && !sref_req) nxt_state = st_idle;
    endcase
  end

  // clock enables low through init and self-refresh
  always_comb
  begin
    nxt_cke = cke_ff;
    unique case (state_ff)
      st_init: nxt_cke = init_end ? dcb_pkg::ROWS_ALL : dcb_pkg::ROWS_NONE;
      // idle rows drop, wanted rows rise first
      st_idle:
        if (sref_go)
          nxt_cke = dcb_pkg::ROWS_NONE;
        else
          nxt_cke = ~pdn_req | (cmd_valid ? cmd_mask : 4'h0) |
                    {4{sref_req}};
      st_sref: nxt_cke = sref_req ? dcb_pkg::ROWS_NONE : dcb_pkg::ROWS_ALL;
      st_wcmd, st_wdata, st_rwait: nxt_cke = cke_ff;
    endcase
  end

  // strobes and selects form the command
  always_comb
  begin
    nxt_sel_n = dcb_pkg::ROWS_ALL;
    nxt_pins = dcb_pkg::dcb_cmd_pins(dcb_pkg::cmd_nop);
    if (take)
    begin
      nxt_sel_n = ~cmd_mask;
      nxt_pins = dcb_pkg::dcb_cmd_pins(cmd_code);
    end
    else if (sref_go)
    begin
      nxt_sel_n = dcb_pkg::ROWS_NONE;
      nxt_pins = dcb_pkg::dcb_cmd_pins(dcb_pkg::cmd_refresh);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= st_init;
      init_cnt_ff <= '0;
      rd_cnt_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == st_init && !init_end)
        init_cnt_ff <= init_cnt_ff + INIT_W'(1);
      if (take)
        rd_cnt_ff <= 3'(RD_SLOTS - 1);
      else if (slot && capture_en && !rd_done)
        rd_cnt_ff <= rd_cnt_ff - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // command pins
  // ----------------------------------------------------------------
  // pins move only as the forwarded clock rises
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_n_ff <= dcb_pkg::ROWS_ALL;
      cke_ff <= dcb_pkg::ROWS_NONE;
      pins_ff <= 3'h7;
    end
    else if (slot)
    begin
      sel_n_ff <= nxt_sel_n;
      cke_ff <= nxt_cke;
      pins_ff <= nxt_pins;
    end
  end

  // address and bank held between commands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_ff <= 13'h0000;
      bank_ff <= 2'h0;
      wbuf0_ff <= '0;
      wbuf1_ff <= '0;
    end
    else if (take)
    begin
      addr_ff <= cmd_addr;
      bank_ff <= cmd_bank;
      wbuf0_ff <= {wr_check0, wr_data0};
      wbuf1_ff <= {wr_check1, wr_data1};
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff <= 1'b0;
      init_done_ff <= 1'b0;
      sref_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_beat_ff <= '0;
    end
    else
    begin
      ack_ff <= take;
      init_done_ff <= nxt_state != st_init;
      sref_ff <= nxt_state == st_sref;
      rd_valid_ff <= lane_edge[0];
      rd_beat_ff <= lane_rd;
    end
  end

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  // lane n pairs strobe n, lane 8 the check byte
  for (genvar l = 0; l < dcb_pkg::N_LANES; l++)
  begin : g_lane
    dcb_byte_lane u_lane (
      .clk(clk),
      .rst_b(rst_b),
      .nxt_drive(nxt_drive),
      .nxt_byte(wr_beat[8*l +: 8]),
      .nxt_strobe(nxt_strobe),
      .capture_en(capture_en),
      .dq_in(l < 8 ? mem_data_bus_in[8*(l%8) +: 8] : check_byte_bus_in),
      .dq_out_ff(all_dq_out[8*l +: 8]),
      .dq_oe_ff(lane_oe[l]),
      .dqs_in(byte_lane_strobe_in[l]),
      .dqs_out_ff(byte_lane_strobe_out[l]),
      .dqs_oe_ff(byte_lane_strobe_oe[l]),
      .rd_byte_ff(lane_rd[8*l +: 8]),
      .rd_edge_ff(lane_edge[l])
    );
    assign all_oe[8*l +: 8] = {8{lane_oe[l]}};
  end

  // data bus and check byte share each beat
  assign mem_data_bus_out = all_dq_out[63:0];
  assign mem_data_bus_oe = all_oe[63:0];
  assign check_byte_bus_out = all_dq_out[71:64];
  assign check_byte_bus_oe = all_oe[71:64];
  assign mem_fwd_clk_true = clk_true_ff;
  assign mem_fwd_clk_comp = clk_comp_ff;
  assign row_select_n = sel_n_ff;
  assign row_clock_enable = cke_ff;
  assign {row_strobe_n, column_strobe_n, write_strobe_n} = pins_ff;
  assign mem_row_col_addr = addr_ff;
  assign bank_addr = bank_ff;
  assign cmd_ack = ack_ff;
  assign init_done = init_done_ff;
  assign sref_active = sref_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_beat_ff[63:0];
  assign rd_check = rd_beat_ff[71:64];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire ck_rise = clk_true_ff[0] & ~fwd_prev_ff;
  wire is_ref = pins_ff == 3'h1;
  wire is_wr = ~(&row_select_n) && pins_ff == 3'h4;

  a_clk_comp_pair: assert property (
    mem_fwd_clk_comp == ~mem_fwd_clk_true &&
    (mem_fwd_clk_true == 6'h00 || mem_fwd_clk_true == 6'h3F))
    else $error("forwarded clock pair not complementary");
  a_clk_period: assert property (
    ck_rise |=> !$rose(mem_fwd_clk_true[0]) [*7] ##1 ck_rise)
    else $error("forwarded clock period not eight cycles");
  a_sel_one_row: assert property (
    !is_ref |-> $onehot0(~row_select_n))
    else $error("more than one row selected");
  a_pins_on_rise: assert property (
    $changed({row_select_n, pins_ff}) |-> ck_rise)
    else $error("command pins moved off the rising edge");
  a_addr_on_rise: assert property (
    $changed(mem_row_col_addr) |-> ck_rise)
    else $error("address moved off the rising edge");
  a_bank_on_rise: assert property (
    $changed(bank_addr) |-> ck_rise)
    else $error("bank moved off the rising edge");
  a_cke_on_rise: assert property (
    $changed(row_clock_enable) |-> ck_rise)
    else $error("clock enable moved off the rising edge");
  a_init_cke_low: assert property (
    !init_done |-> row_clock_enable == 4'h0 && &row_select_n)
    else $error("memory touched before init completed");
  a_sel_row_awake: assert property (
    (~row_select_n & ~row_clock_enable) != 4'h0 |-> is_ref)
    else $error("command sent to a powered-down row");
  a_truth_table: assert property (
    cmd_ack |-> pins_ff == dcb_pkg::dcb_cmd_pins($past(cmd_code)))
    else $error("command strobes do not match command");
  a_wr_data_follow: assert property (
    is_wr && ck_rise |-> ##8 mem_data_bus_oe[0] [*8] ##1 !mem_data_bus_oe[0])
    else $error("write data not driven in the following clock");
  a_wr_strobe_mid: assert property (
    $changed(byte_lane_strobe_out[0]) && byte_lane_strobe_oe[0] |->
    $stable(mem_data_bus_out[7:0]) ##1 $stable(mem_data_bus_out[7:0]))
    else $error("write strobe edge not centred in data");
  a_lanes_together: assert property (
    byte_lane_strobe_oe == {9{mem_data_bus_oe[0]}})
    else $error("byte lane strobes not driven together");
  a_check_with_data: assert property (
    check_byte_bus_oe == {8{mem_data_bus_oe[63]}})
    else $error("check byte not driven with data");
  a_rd_in_window: assert property (
    rd_valid |-> $past(capture_en, 2))
    else $error("read beat captured outside read window");

  c_write: cover property (is_wr && ck_rise);
  c_read_beat: cover property (rd_valid ##[1:8] rd_valid);
  c_self_refresh: cover property ($rose(sref_active));
  c_power_down: cover property (init_done && $fell(row_clock_enable[0]));
endmodule : dcb_channel

// ===== tb/dcb_mem_model.sv
module dcb_mem_model (
  // pins from the device
  input wire logic fwd_clk,
  input wire logic [3:0] sel_n,
  input wire logic [2:0] cmd_n,
  input wire logic [71:0] beat_pin,
  input wire logic [8:0] stb_pin,
  // read beats to return
  input wire logic [71:0] rd_beat0,
  input wire logic [71:0] rd_beat1,
  // memory drive
  output logic [71:0] beat_mem,
  output logic [8:0] stb_mem,
  // write beats as latched
  output logic [71:0] wr_seen0,
  output logic [71:0] wr_seen1
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    beat_mem = 72'h0;
    stb_mem = 9'h000;
    wr_seen0 = 72'h0;
    wr_seen1 = 72'h0;
  end
  // sampled mid-period, clear of the launch edge
  always @(negedge fwd_clk)
  begin
    if (sel_n != 4'hF && cmd_n == 3'h5)
    begin
      #123;
      beat_mem = rd_beat0;
      stb_mem = 9'h1FF;
      #80;
      beat_mem = rd_beat1;
      stb_mem = 9'h000;
      #80;
      // released: inverse, never the stale beat
      beat_mem = ~rd_beat1;
    end
    else if (sel_n != 4'hF && cmd_n == 3'h4)
    begin
      @(posedge stb_pin[0]);
      wr_seen0 = beat_pin;
      @(negedge stb_pin[0]);
      wr_seen1 = beat_pin;
    end
  end
endmodule : dcb_mem_model

// ===== tb/dcb_channel_tb.sv
module dcb_channel_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // signals
  // ------
  logic clk, rst_b, cmd_valid, cmd_ack, rd_valid, sref_req;
  logic init_done, sref_active, ras_n, cas_n, we_n, fwd_q;
  dcb_pkg::dcb_cmd_type cmd_code;
  logic [1:0] cmd_row, cmd_bank, bank_addr;
  logic [12:0] cmd_addr, addr;
  logic [63:0] wr_data0, wr_data1, rd_data, dq_out, dq_oe, dq_in;
  logic [7:0] wr_check0, wr_check1, rd_check, ck_out, ck_oe, ck_in;
  logic [3:0] pdn_req, sel_n, cke, cke_q, sel_q;
  logic [5:0] fwd_t, fwd_c;
  logic [8:0] stb_out, stb_oe, stb_in, stb_mem;
  logic [71:0] beat_mem, rd_beat0, rd_beat1, wr_seen0, wr_seen1;
  int err_total, total_checks;
  localparam logic [2:0] PINS [7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1,
                                      3'h0};
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & beat_mem[63:0]);
  assign ck_in = (ck_oe & ck_out) | (~ck_oe & beat_mem[71:64]);
  assign stb_in = (stb_oe & stb_out) | (~stb_oe & stb_mem);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  dcb_channel #(.INIT_CYCLES(16), .RD_SLOTS(4)) i_dut (.clk(clk),
    .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_row(cmd_row), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .wr_data0(wr_data0), .wr_check0(wr_check0), .wr_data1(wr_data1),
    .wr_check1(wr_check1), .cmd_ack(cmd_ack), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_check(rd_check), .pdn_req(pdn_req),
    .sref_req(sref_req), .init_done(init_done), .sref_active(sref_active),
    .mem_fwd_clk_true(fwd_t), .mem_fwd_clk_comp(fwd_c),
    .row_select_n(sel_n), .row_clock_enable(cke),
    .mem_row_col_addr(addr), .bank_addr(bank_addr),
    .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_strobe_n(we_n),
    .mem_data_bus_in(dq_in), .mem_data_bus_out(dq_out),
    .mem_data_bus_oe(dq_oe), .check_byte_bus_in(ck_in),
    .check_byte_bus_out(ck_out), .check_byte_bus_oe(ck_oe),
    .byte_lane_strobe_in(stb_in), .byte_lane_strobe_out(stb_out),
    .byte_lane_strobe_oe(stb_oe));
  dcb_mem_model i_mem (.fwd_clk(fwd_t[0]), .sel_n(sel_n),
    .cmd_n({ras_n, cas_n, we_n}), .beat_pin({ck_in, dq_in}),
    .stb_pin(stb_in), .rd_beat0(rd_beat0), .rd_beat1(rd_beat1),
    .beat_mem(beat_mem), .stb_mem(stb_mem), .wr_seen0(wr_seen0),
    .wr_seen1(wr_seen1));
  // ------
  // helpers
  // ------
  task automatic check(input string what, input logic [80:0] seen,
                       input logic [80:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic issue(input dcb_pkg::dcb_cmd_type c, input logic [1:0] r,
                       input logic [12:0] a);
    int n;
    @(negedge clk);
    n = 0;
    cmd_code = c;
    {cmd_row, cmd_bank, cmd_addr} = {r, ~r, a};
    cmd_valid = 1'b1;
    while (n < 200 && cmd_ack !== 1'b1)
    begin
      tick();
      n++;
    end
    check("ack", cmd_ack, 1'h1);
    check("sel", sel_n, 4'(~(4'h1 << r)));
    check("cmd", {ras_n, cas_n, we_n}, PINS[c]);
    check("addr", {bank_addr, addr}, {~r, a});
    check("cke_up", cke[r], 1'h1);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : issue
  // select and clock enable move only as the forwarded clock rises
  always @(posedge clk)
  begin
    #1;
    if (rst_b && (cke !== cke_q || sel_n !== sel_q))
      check("pin_edge", {fwd_q, fwd_t[0]}, 2'h1);
    cke_q = cke;
    sel_q = sel_n;
    fwd_q = fwd_t[0];
  end
  // ------
  // scenarios
  // ------
  task automatic t_init();
    int n;
    n = 0;
    while (n < 120 && (init_done !== 1'b1 || cke !== 4'hF))
    begin
      tick();
      n++;
    end
    check("init_cke", {init_done, cke}, 5'h1F);
    $display("test init done");
  endtask : t_init
  task automatic t_clocks();
    int rises;
    logic prev;
    rises = 0;
    prev = fwd_t[0];
    repeat (16)
    begin
      tick();
      rises += (fwd_t[0] && !prev) ? 1 : 0;
      prev = fwd_t[0];
      check("fwd", {fwd_c, fwd_t}, {~fwd_t, {6{fwd_t[0]}}});
    end
    check("fwd_rate", rises, 2);
    $display("test clocks done");
  endtask : t_clocks
  task automatic t_cmds();
    dcb_pkg::dcb_cmd_type seq [5] = '{dcb_pkg::cmd_activate,
      dcb_pkg::cmd_precharge, dcb_pkg::cmd_refresh, dcb_pkg::cmd_mode_set,
      dcb_pkg::cmd_nop};
    // back to back, one per slot
    for (int i = 0; i < 5; i++)
      issue(seq[i], 2'(i), 13'h1FFF >> i);
    $display("test commands done");
  endtask : t_cmds
  task automatic t_write();
    @(negedge clk);
    {wr_check0, wr_data0} = 72'hA5_0123_4567_89AB_CDEF;
    {wr_check1, wr_data1} = 72'h5A_FEDC_BA98_7654_3210;
    issue(dcb_pkg::cmd_write, 2'h1, 13'h0400);
    repeat (8) @(posedge clk);
    #1;
    check("wr_oe", {dq_oe, ck_oe, stb_oe}, {81{1'b1}});
    check("wr_b0", {ck_out, dq_out}, {wr_check0, wr_data0});
    repeat (2) @(posedge clk);
    #1;
    check("wr_stb", stb_out, 9'h1FF);
    repeat (6) @(posedge clk);
    #1;
    check("wr_off", {dq_oe, ck_oe, stb_oe}, 81'h0);
    check("wr_l0", wr_seen0, {wr_check0, wr_data0});
    check("wr_l1", wr_seen1, {wr_check1, wr_data1});
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    int n;
    @(negedge clk);
    rd_beat0 = 72'hC3_0011_2233_4455_6677;
    rd_beat1 = 72'h3C_8899_AABB_CCDD_EEFF;
    issue(dcb_pkg::cmd_read, 2'h3, 13'h0008);
    for (int b = 0; b < 2; b++)
    begin
      n = 0;
      while (n < 60 && rd_valid !== 1'b1)
      begin
        tick();
        n++;
      end
      check("rd", {rd_check, rd_data}, b ? rd_beat1 : rd_beat0);
      tick();
    end
    $display("test read done");
  endtask : t_read
  task automatic t_power();
    int n;
    @(negedge clk);
    pdn_req = 4'h4;
    n = 0;
    while (n < 24 && cke !== 4'hB)
    begin
      tick();
      n++;
    end
    check("pdn", cke, 4'hB);
    issue(dcb_pkg::cmd_activate, 2'h2, 13'h0123);
    pdn_req = 4'h0;
    sref_req = 1'b1;
    n = 0;
    while (n < 80 && sref_active !== 1'b1)
    begin
      tick();
      n++;
    end
    check("sref", {sel_n, ras_n, cas_n, we_n, cke}, 11'h010);
    @(negedge clk);
    sref_req = 1'b0;
    n = 0;
    while (n < 24 && cke !== 4'hF)
    begin
      tick();
      n++;
    end
    check("sref_out", {sref_active, cke}, 5'h0F);
    $display("test power done");
  endtask : t_power
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    {err_total, total_checks} = '0;
    {rst_b, cmd_valid, pdn_req, sref_req, cmd_row, cmd_bank} = '0;
    {cmd_addr, wr_data0, wr_data1, wr_check0, wr_check1} = '0;
    {rd_beat0, rd_beat1, cke_q, fwd_q} = '0;
    cmd_code = dcb_pkg::cmd_nop;
    sel_q = 4'hF;
    repeat (8) @(negedge clk);
    check("rst_fwd", {fwd_t, fwd_c}, 12'h03F);
    check("rst_pin", {sel_n, cke, ras_n, cas_n, we_n}, 11'h787);
    check("rst_oe", {dq_oe, ck_oe, stb_oe}, 81'h0);
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    t_init();
    t_clocks();
    t_cmds();
    t_write();
    t_read();
    t_power();
    tally_and_finish();
  end
  // about seven times the expected run of some 4 us
  initial
  begin
    #30000;
    err_total++;
    tally_and_finish();
  end
endmodule : dcb_channel_tb
